//--- rtl/ucd_ctrl.v
// Serial control register 3, data buffer, error interrupts and pin control
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ucd_regs.vh"

module ucd_ctrl (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_b,
	// AXI4-Lite write address
	input  wire [7:0]  i_s_axi_awaddr,
	input  wire        i_s_axi_awvalid,
	output wire        o_s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] i_s_axi_wdata,
	input  wire [3:0]  i_s_axi_wstrb,
	input  wire        i_s_axi_wvalid,
	output wire        o_s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  o_s_axi_bresp,
	output reg         o_s_axi_bvalid,
	input  wire        i_s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  i_s_axi_araddr,
	input  wire        i_s_axi_arvalid,
	output wire        o_s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] o_s_axi_rdata,
	output reg  [1:0]  o_s_axi_rresp,
	output reg         o_s_axi_rvalid,
	input  wire        i_s_axi_rready,
	// Error events from the receiver core, one-cycle pulses
	input  wire        i_overrun_event,
	input  wire        i_noise_event,
	input  wire        i_framing_event,
	input  wire        i_parity_event,
	// Receive shifter side
	input  wire        i_rx_load,
	input  wire [9:0]  i_rx_char,
	input  wire        i_rxd,
	output reg         o_rx_serial,
	output reg         o_rx_read_strobe,
	// Transmit shifter side
	input  wire        i_tx_serial,
	input  wire        i_tx_busy,
	output reg  [9:0]  o_tx_data,
	output reg         o_tx_load,
	// Transmit pin, three signals
	input  wire        i_txd_in,
	output reg         o_txd_out,
	output reg         o_txd_oe,
	// Interrupt request
	output wire        o_irq
);

	// ************************************************************
	// Register state
	// ************************************************************
	reg         tx_tenth_bit;
	reg         tx_ninth_bit;
	reg         single_wire_pin_direction;
	reg         transmit_polarity_invert;
	reg  [3:0]  irq_enable;
	reg  [3:0]  error_status;
	reg  [3:0]  next_error_status;
	reg         loop_select;
	reg         receiver_source_select;
	reg         drive_hold;
	wire [9:0]  rx_buffer;

	// ************************************************************
	// Bus write channel state
	// ************************************************************
	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire        wr_do;
	wire        wr_lane0;
	wire        rd_take;
	wire        single_wire;
	wire        pin_drive;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	wire [3:0]  error_events;
	wire        status_read;

	// Handshake readiness
	assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
	assign o_s_axi_wready  = !w_held && !o_s_axi_bvalid;
	assign o_s_axi_arready = !o_s_axi_rvalid;
	assign wr_do           = aw_held && w_held && !o_s_axi_bvalid;
	assign wr_lane0        = wr_do && w_strb[0];
	assign rd_take         = i_s_axi_arvalid && !o_s_axi_rvalid;
	assign status_read     = rd_take && (i_s_axi_araddr == `UCD_ADDR_STATUS);

	// ************************************************************
	// Write address and data capture, either order
	// ************************************************************
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else begin
			// Address half waits here until its data arrives
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_s_axi_awaddr;
			end else if (wr_do) begin
				aw_held <= 1'b0;
			end
			// Data half waits here until its address arrives
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
			end else if (wr_do) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response, one cycle after both halves are held
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= `UCD_RESP_OKAY;
		end else if (wr_do) begin
			o_s_axi_bvalid <= 1'b1;
			// Only the four mapped words answer OKAY
			case (aw_addr)
				`UCD_ADDR_CTRL3,
				`UCD_ADDR_DATA,
				`UCD_ADDR_STATUS,
				`UCD_ADDR_MODE: begin
					o_s_axi_bresp <= `UCD_RESP_OKAY;
				end
				default: begin
					o_s_axi_bresp <= `UCD_RESP_SLVERR;
				end
			endcase
		end else if (o_s_axi_bvalid && i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Control register 3 and mode register
	// ************************************************************
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_tenth_bit              <= 1'b0;
			tx_ninth_bit              <= 1'b0;
			single_wire_pin_direction <= 1'b0;
			transmit_polarity_invert  <= 1'b0;
			irq_enable                <= 4'h0;
			loop_select               <= 1'b0;
			receiver_source_select    <= 1'b0;
		end else if (wr_lane0) begin
			if (aw_addr == `UCD_ADDR_CTRL3) begin
				tx_tenth_bit              <= w_data[`UCD_C3_RX9_TX10];
				tx_ninth_bit              <= w_data[`UCD_C3_RX10_TX9];
				single_wire_pin_direction <= w_data[`UCD_C3_PIN_DIR];
				transmit_polarity_invert  <= w_data[`UCD_C3_TX_INV];
				irq_enable                <= w_data[3:0];
			end
			if (aw_addr == `UCD_ADDR_MODE) begin
				loop_select            <= w_data[`UCD_MODE_LOOP];
				receiver_source_select <= w_data[`UCD_MODE_RXSRC];
			end
		end
	end

	// ************************************************************
	// Transmit buffer load from the data location
	// ************************************************************
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tx_data <= 10'h000;
			o_tx_load <= 1'b0;
		end else begin
			o_tx_load <= wr_lane0 && (aw_addr == `UCD_ADDR_DATA);
			if (wr_lane0 && (aw_addr == `UCD_ADDR_DATA)) begin
				// Extra bits taken from control register at this write
				o_tx_data <= {tx_tenth_bit, tx_ninth_bit, w_data[7:0]};
			end
		end
	end

	// ************************************************************
	// Receive buffer
	// ************************************************************
	// Buffer takes a new character on the same edge that samples the load pulse
	ucd_rx_buffer u_rx_buffer (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_load  (i_rx_load),
		.i_char  (i_rx_char),
		.o_char  (rx_buffer)
	);

	// ************************************************************
	// Read data multiplexer
	// ************************************************************
	always @* begin
		// Chosen from the bus address, unmapped reads give zero
		next_rdata = 32'h00000000;
		next_rresp = `UCD_RESP_OKAY;
		case (i_s_axi_araddr)
			`UCD_ADDR_CTRL3: begin
				// Reads show received extra bits, not transmit ones
				next_rdata[7:0] = {rx_buffer[8], rx_buffer[9],
					single_wire_pin_direction, transmit_polarity_invert,
					irq_enable};
			end
			`UCD_ADDR_DATA: begin
				next_rdata[7:0] = rx_buffer[7:0];
			end
			`UCD_ADDR_STATUS: begin
				next_rdata[3:0] = error_status;
			end
			`UCD_ADDR_MODE: begin
				next_rdata[1:0] = {receiver_source_select, loop_select};
			end
			default: begin
				next_rresp = `UCD_RESP_SLVERR;
			end
		endcase
	end

	// Read answer one cycle after the address is taken
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_s_axi_rvalid   <= 1'b0;
			o_s_axi_rdata    <= 32'h00000000;
			o_s_axi_rresp    <= `UCD_RESP_OKAY;
			o_rx_read_strobe <= 1'b0;
		end else begin
			// Tells the core the data location was read
			o_rx_read_strobe <= rd_take && (i_s_axi_araddr == `UCD_ADDR_DATA);
			if (rd_take) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata  <= next_rdata;
				o_s_axi_rresp  <= next_rresp;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Sticky error status, cleared by a read, set wins
	// ************************************************************
	// Event pulses in status bit order
	assign error_events = {i_overrun_event, i_noise_event, i_framing_event, i_parity_event};

	always @* begin
		// Clear first, so an event in the same cycle survives
		next_error_status = error_status;
		if (status_read) begin
			next_error_status = 4'h0;
		end
		next_error_status = next_error_status | error_events;
	end

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			error_status <= `UCD_ST_RESET;
		end else begin
			error_status <= next_error_status;
		end
	end

	// Interrupt request, level while an enabled flag is set
	assign o_irq = (error_status[`UCD_ST_OVR]    & irq_enable[`UCD_C3_OVR_IE])
	             | (error_status[`UCD_ST_NOISE]  & irq_enable[`UCD_C3_NOISE_IE])
	             | (error_status[`UCD_ST_FRAME]  & irq_enable[`UCD_C3_FRAME_IE])
	             | (error_status[`UCD_ST_PARITY] & irq_enable[`UCD_C3_PARITY_IE]);

	// ************************************************************
	// Single-wire pin direction
	// ************************************************************
	assign single_wire = loop_select && receiver_source_select;

	// Keep driving until the character in flight has finished
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			drive_hold <= 1'b0;
		end else if (single_wire_pin_direction) begin
			drive_hold <= 1'b1;
		end else if (!i_tx_busy) begin
			drive_hold <= 1'b0;
		end
	end

	// Drive while direction is set or the last character drains
	assign pin_drive = single_wire_pin_direction || (drive_hold && i_tx_busy);

	// ************************************************************
	// Pin and receiver source routing
	// ************************************************************
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_txd_out   <= 1'b1;
			o_txd_oe    <= 1'b0;
			o_rx_serial <= 1'b1;
		end else begin
			// Inversion covers idle and break too
			o_txd_out <= i_tx_serial ^ transmit_polarity_invert;
			if (single_wire) begin
				// Direction decides who owns the shared line
				o_txd_oe    <= pin_drive;
				o_rx_serial <= pin_drive ? 1'b1 : i_txd_in;
			end else if (loop_select) begin
				// Transmitter feeds the receiver internally
				o_txd_oe    <= 1'b1;
				o_rx_serial <= i_tx_serial;
			end else begin
				// Separate receive pin
				o_txd_oe    <= 1'b1;
				o_rx_serial <= i_rxd;
			end
		end
	end

endmodule // ucd_ctrl

//--- rtl/ucd_regs.vh
// Register map, field positions and reset values of the serial control block
`ifndef UCD_REGS_VH
`define UCD_REGS_VH

// ************************************************************
// Register indices and byte addresses
// ************************************************************
`define UCD_IDX_CTRL3      8'h06
`define UCD_IDX_DATA       8'h07
`define UCD_IDX_STATUS     8'h10
`define UCD_IDX_MODE       8'h11
`define UCD_ADDR_CTRL3     8'h18
`define UCD_ADDR_DATA      8'h1C
`define UCD_ADDR_STATUS    8'h40
`define UCD_ADDR_MODE      8'h44

// ************************************************************
// Control register 3 fields
// ************************************************************
`define UCD_C3_RX9_TX10    7
`define UCD_C3_RX10_TX9    6
`define UCD_C3_PIN_DIR     5
`define UCD_C3_TX_INV      4
`define UCD_C3_OVR_IE      3
`define UCD_C3_NOISE_IE    2
`define UCD_C3_FRAME_IE    1
`define UCD_C3_PARITY_IE   0
`define UCD_C3_RESET       8'h00

// ************************************************************
// Status and mode register fields
// ************************************************************
`define UCD_ST_OVR         3
`define UCD_ST_NOISE       2
`define UCD_ST_FRAME       1
`define UCD_ST_PARITY      0
`define UCD_ST_RESET       4'h0
`define UCD_MODE_LOOP      0
`define UCD_MODE_RXSRC     1
`define UCD_MODE_RESET     2'h0

// ************************************************************
// Bus answers
// ************************************************************
`define UCD_RESP_OKAY      2'h0
`define UCD_RESP_SLVERR    2'h2

`endif

//--- rtl/ucd_rx_buffer.v
// Receive data holding buffer with registered read port
`timescale 1ns/1ps

module ucd_rx_buffer (
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rst_b,
	// Load side from the receive shifter
	input  wire       i_load,
	input  wire [9:0] i_char,
	// Read side
	output reg  [9:0] o_char
);

	// Hold the last received character until the next load
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_char <= 10'h000;
		end else if (i_load) begin
			o_char <= i_char;
		end
	end

endmodule // ucd_rx_buffer

//--- tb/ucd_ctrl_checker.sv
// Port-level assertions for the serial control block
`timescale 1ns/1ps

module ucd_ctrl_checker (
	// Clock and reset
	input wire        i_clk,
	input wire        i_rst_b,
	// Register bus
	input wire [7:0]  i_s_axi_araddr,
	input wire        i_s_axi_arvalid,
	input wire        o_s_axi_arready,
	input wire        o_s_axi_awready,
	input wire        o_s_axi_wready,
	input wire        o_s_axi_bvalid,
	input wire        i_s_axi_bready,
	input wire        o_s_axi_rvalid,
	input wire        i_s_axi_rready,
	// Events and core side
	input wire        i_overrun_event,
	input wire        i_noise_event,
	input wire        i_framing_event,
	input wire        i_parity_event,
	input wire        o_rx_read_strobe,
	input wire        o_tx_load,
	input wire        i_tx_busy,
	input wire        o_txd_oe,
	input wire        o_irq
);
	// ************************************************************
	// Timing relations
	// ************************************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Any error event this cycle
	wire any_ev = i_overrun_event | i_noise_event | i_framing_event | i_parity_event;
	// Read address taken, and both write halves held
	wire ar_taken  = i_s_axi_arvalid && o_s_axi_arready;
	wire wr_closed = !o_s_axi_awready && !o_s_axi_wready;
	sequence s_data_rd;
		i_s_axi_arvalid && o_s_axi_arready && (i_s_axi_araddr == 8'h1C);
	endsequence
	sequence s_answer;
		$rose(o_s_axi_bvalid) || $rose(o_s_axi_rvalid);
	endsequence
	chk_strobe_on_read: assert property (s_data_rd |=> o_rx_read_strobe)
		else $error("no read strobe after data read");
	chk_strobe_cause: assert property ($rose(o_rx_read_strobe) |-> $past(i_s_axi_arvalid))
		else $error("read strobe without read");
	chk_load_pulse: assert property (o_tx_load |=> !o_tx_load)
		else $error("transmit load longer than one cycle");
	chk_load_cause: assert property ($rose(o_tx_load) |-> $rose(o_s_axi_bvalid))
		else $error("transmit load without write");
	chk_ar_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read accepted while answer pending");
	chk_wr_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write accepted while answer pending");
	chk_r_cause: assert property ($rose(o_s_axi_rvalid) |-> $past(ar_taken))
		else $error("read answer without accepted address");
	chk_b_cause: assert property ($rose(o_s_axi_bvalid) |-> $past(wr_closed))
		else $error("write answer before both halves taken");
	chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("write answer dropped early");
	chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
		else $error("read answer dropped early");
	chk_irq_rise: assert property ($rose(o_irq) |-> $past(any_ev) or s_answer)
		else $error("interrupt rose without cause");
	chk_irq_fall: assert property ($fell(o_irq) |-> s_answer)
		else $error("interrupt fell without cause");
	chk_oe_release: assert property ($fell(o_txd_oe) |-> !$past(i_tx_busy))
		else $error("pin released during character");
endmodule // ucd_ctrl_checker

bind ucd_ctrl ucd_ctrl_checker u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
	.o_s_axi_arready(o_s_axi_arready), .o_s_axi_awready(o_s_axi_awready),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_bready(i_s_axi_bready), .o_s_axi_rvalid(o_s_axi_rvalid),
	.i_s_axi_rready(i_s_axi_rready), .i_overrun_event(i_overrun_event),
	.i_noise_event(i_noise_event), .i_framing_event(i_framing_event),
	.i_parity_event(i_parity_event), .o_rx_read_strobe(o_rx_read_strobe),
	.o_tx_load(o_tx_load), .i_tx_busy(i_tx_busy), .o_txd_oe(o_txd_oe), .o_irq(o_irq));

//--- tb/ucd_peer.sv
// Remote serial peer on the shared transmit pin and receive line
`timescale 1ns/1ps

module ucd_peer (
	// Block pin side
	input  wire  i_oe,
	input  wire  i_txd,
	// Peer drive control
	input  wire  i_drv,
	input  wire  i_val,
	// Line levels
	output logic o_pin,
	output logic o_rxd
);
	// Pull-up gives idle high when nobody drives
	assign o_pin = i_oe ? i_txd : (i_drv ? i_val : 1'b1);
	assign o_rxd = i_drv ? i_val : 1'b1;
endmodule // ucd_peer

//--- tb/uart_ctrl3_and_data_buffer_tb.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ps

module uart_ctrl3_and_data_buffer_tb;
	logic        clk, rst_b, awv, wv, brd, arv, rrd, rxl, busy, ser, drv, val;
	logic        awr, wrd, bv, arr, rv, rxs, tl, to, oe, irq, pin, rxd;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdt, d;
	logic [3:0]  ev;
	logic [9:0]  rxc, txd, txc;
	logic [1:0]  br, rr, r;
	int          fail_count, checks_done;

	ucd_ctrl u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wrd), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(brd),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdt),
		.o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd), .i_overrun_event(ev[3]),
		.i_noise_event(ev[2]), .i_framing_event(ev[1]), .i_parity_event(ev[0]),
		.i_rx_load(rxl), .i_rx_char(rxc), .i_rxd(rxd), .o_rx_serial(rxs), .o_rx_read_strobe(),
		.i_tx_serial(ser), .i_tx_busy(busy), .o_tx_data(txd), .o_tx_load(tl), .i_txd_in(pin),
		.o_txd_out(to), .o_txd_oe(oe), .o_irq(irq));
	ucd_peer u_peer (.i_oe(oe), .i_txd(to), .i_drv(drv), .i_val(val), .o_pin(pin), .o_rxd(rxd));

	// Capture transmit word on each load pulse
	always @(posedge clk) if (tl === 1'b1) txc <= txd;

	// ************************************************************
	// Bus and check helpers
	// ************************************************************
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task settle;
		repeat (3) @(negedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		logic ha, hw, hb;
		@(posedge clk);
		awa <= a; awv <= 1; wd <= {24'h0, v}; wv <= 1; brd <= 1; hb = 0;
		while (!hb) begin
			@(negedge clk);
			ha = awv && awr; hw = wv && wrd; hb = bv; r = br;
			@(posedge clk);
			if (ha) awv <= 0;
			if (hw) wv <= 0;
			if (hb) brd <= 0;
		end
	endtask
	task rd(input logic [7:0] a);
		logic ha, hr;
		@(posedge clk);
		ara <= a; arv <= 1; rrd <= 1; hr = 0;
		while (!hr) begin
			@(negedge clk);
			ha = arv && arr; hr = rv; d = rdt; r = rr;
			@(posedge clk);
			if (ha) arv <= 0;
			if (hr) rrd <= 0;
		end
	endtask
	task pulse(input logic [3:0] e);
		@(posedge clk) ev <= e;
		@(posedge clk) ev <= 4'h0;
		settle;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset;
		rd(8'h18); chk(d, 32'h0);
		chk(oe, 1);
		@(posedge clk) begin drv <= 1; val <= 0; end
		settle; chk(rxs, 0);
		@(posedge clk) drv <= 0;
		rd(8'h30); chk(d, 32'h0); chk(r, 2'h2);
		wr(8'h30, 8'hFF); chk(r, 2'h2);
	endtask
	task t_data;
		wr(8'h18, 8'h40);
		@(posedge clk) begin rxl <= 1; rxc <= 10'h2A5; end
		@(posedge clk) rxl <= 0;
		wr(8'h1C, 8'hC3); settle; chk(txc, 10'h1C3);
		wr(8'h1C, 8'h3C); settle; chk(txc, 10'h13C);
		wr(8'h18, 8'h80); wr(8'h1C, 8'h5A); settle; chk(txc, 10'h25A);
		rd(8'h18); chk(d, 32'h40);
		rd(8'h1C); chk(d, 32'hA5);
	endtask
	task t_irq;
		for (int i = 0; i < 4; i++) begin
			wr(8'h18, 8'(8'h01 << i));
			pulse(4'hF ^ 4'(4'h1 << i)); chk(irq, 0);
			pulse(4'(4'h1 << i)); chk(irq, 1);
			rd(8'h40); chk(d, 32'hF); settle; chk(irq, 0);
		end
	endtask
	task t_pin;
		wr(8'h44, 8'h01); wr(8'h18, 8'h00); settle; chk(oe, 1);
		@(posedge clk) ser <= 0;
		settle; chk(rxs, 0);
		@(posedge clk) ser <= 1;
		wr(8'h44, 8'h03); settle; chk(oe, 0);
		@(posedge clk) begin drv <= 1; val <= 0; end
		settle; chk(rxs, 0);
		@(posedge clk) drv <= 0;
		wr(8'h18, 8'h20); settle; chk({oe, rxs}, 2'h3);
		@(posedge clk) busy <= 1;
		wr(8'h18, 8'h00); settle; chk(oe, 1);
		@(posedge clk) busy <= 0;
		settle; chk(oe, 0);
		wr(8'h44, 8'h00); settle; chk(to, 1);
		wr(8'h18, 8'h10);
		for (int b = 0; b < 2; b++) begin
			@(posedge clk) ser <= b[0];
			settle; chk(to, !b[0]);
		end
	endtask

	task wrap_up;
		$display("mismatches %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Clock source
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Watchdog against a hung handshake
	initial begin
		#300000;
		fail_count++;
		wrap_up;
	end
	// Main sequence
	initial begin
		{rst_b, awv, wv, brd, arv, rrd, rxl, busy, drv, val, ev} = 0;
		{awa, ara, wd, rxc, fail_count, checks_done} = 0;
		ser = 1;
		repeat (16) @(posedge clk);
		rst_b <= 1;
		t_reset;
		t_data;
		t_irq;
		t_pin;
		wrap_up;
	end
endmodule // uart_ctrl3_and_data_buffer_tb
